// [rtl/cam_pkg.sv]
package cam_pkg;

  // Axis and table geometry
  localparam int NUM_AXES      = 8;    // One master plus up to seven slaves
  localparam int AXIS_W        = 3;    // Axis select width
  localparam int POS_W         = 32;   // Encoder and slave position width
  localparam int CYC_W         = 23;   // Master cycle width, max 8,388,607
  localparam int CHG_W         = 31;   // Slave change width, max 2,147,483,647
  localparam int NUM_INTERVALS = 256;  // Table intervals
  localparam int NUM_POINTS    = 257;  // Points 0..256
  localparam int IDX_W         = 9;    // Point index width

  // Field limits
  localparam logic [CYC_W-1:0] CYCLE_MAX  = 23'h7fffff;
  localparam logic [POS_W-1:0] CHANGE_MAX = 32'h7fffffff;
  localparam logic [IDX_W-1:0] LAST_SEG   = 9'h0ff;

  // Wishbone byte addresses
  localparam int ADR_W = 10;
  localparam logic [ADR_W-1:0] ADR_CTRL     = 10'h000;
  localparam logic [ADR_W-1:0] ADR_CYCLE    = 10'h004;
  localparam logic [ADR_W-1:0] ADR_INTERVAL = 10'h008;
  localparam logic [ADR_W-1:0] ADR_START    = 10'h00c;
  localparam logic [ADR_W-1:0] ADR_STATUS   = 10'h010;
  localparam logic [ADR_W-1:0] ADR_MPOS     = 10'h014;
  localparam logic [ADR_W-1:0] ADR_TBL_IDX  = 10'h018;
  localparam logic [ADR_W-1:0] ADR_TBL_AXIS = 10'h01c;
  localparam logic [ADR_W-1:0] ADR_TBL_DATA = 10'h020;

  // Per-axis register groups, selected by address bits 9:5, axis in 4:2
  localparam logic [4:0] GRP_CHANGE   = 5'h02;  // 0x040 + 4*axis
  localparam logic [4:0] GRP_ENGAGE   = 5'h03;  // 0x060 + 4*axis
  localparam logic [4:0] GRP_DISENG   = 5'h04;  // 0x080 + 4*axis

  // Control field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_AX_LSB   = 4;
  localparam int CTRL_SEL_BIT  = 7;

  // Reset values
  localparam logic [CYC_W-1:0] CYCLE_RST    = 23'h000000;
  localparam logic [CYC_W-1:0] INTERVAL_RST = 23'h000000;
  localparam logic [CYC_W-1:0] START_RST    = 23'h000000;
  localparam logic [AXIS_W-1:0] MASTER_RST  = 3'h0;
  localparam logic [POS_W-1:0] POS_RST      = 32'h00000000;

endpackage : cam_pkg

// [rtl/electronic_cam_follower.sv]
// Functional notes
// - One master drives at most seven slaves
// - Master position comes from main encoder only
// - Master selection precedes all other cam setup
// - Master position wrapped into zero..cycle length minus one
// - Cycle end zeroes master and slave relative
// - Cycle up to 8388607, change 2147483647
// - Table uniformly spaced, at most 256 intervals
// - Interval command sets width, start command the first point
// - Table entry per axis, index 0..256
// - Enable one activates cam, zero deactivates
// - Engage position per slave starts following
// - Engage outside cycle engages at once
// - Engaged slave position expressed modulo change
// - Disengage position per slave stops following
// - Disengage outside cycle stops at once
// - Scheduled points trigger only on forward travel
`timescale 1ns/1ns
`default_nettype none

module electronic_cam_follower
  import cam_pkg::*;
(
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic [ADR_W-1:0]                   wb_adr_i,
  input  wire logic [31:0]                        wb_dat_i,
  input  wire logic [3:0]                         wb_sel_i,
  input  wire logic                               wb_we_i,
  input  wire logic                               wb_cyc_i,
  input  wire logic                               wb_stb_i,
  output logic      [31:0]                        wb_dat_o,
  output logic                                    wb_ack_o,
  input  wire logic [NUM_AXES-1:0][POS_W-1:0]     main_enc_i,
  output logic      [NUM_AXES-1:0][POS_W-1:0]     slave_cmd_o,
  output logic      [NUM_AXES-1:0]                slave_engaged_o,
  output logic      [CYC_W-1:0]                   master_pos_o,
  output logic                                    master_fwd_o
);

  // Merge write data into an old word by byte enables
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Forward crossing of target t between old and new master positions
  function automatic logic crossed(input logic [POS_W-1:0] t,
                                   input logic [CYC_W-1:0] p_old,
                                   input logic [CYC_W-1:0] p_new,
                                   input logic             wrp);
    logic gt_old;
    logic le_new;
    gt_old = t > {9'h000, p_old};
    le_new = t <= {9'h000, p_new};
    return wrp ? (gt_old | le_new) : (gt_old & le_new);
  endfunction : crossed

  // Control and setup registers
  logic                    enable_r;      // Cam mode active
  logic [AXIS_W-1:0]       master_ax_r;   // Selected master axis
  logic                    master_ok_r;   // A master has been chosen
  logic [CYC_W-1:0]        cycle_r;       // Master cycle length
  logic [CYC_W-1:0]        interval_r;    // Width of one table interval
  logic [CYC_W-1:0]        start_r;       // Master position of point 0
  logic [IDX_W-1:0]        tbl_idx_r;     // Table point pointer
  logic [AXIS_W-1:0]       tbl_ax_r;      // Table axis pointer
  logic [POS_W-1:0]        table_r [NUM_POINTS][NUM_AXES];  // Cam table

  // Master tracking
  logic [POS_W-1:0]        enc_prev_r;    // Last sampled master encoder
  logic [CYC_W-1:0]        mpos_r;        // Wrapped master position
  logic                    fwd_r;         // Master moved forward last step

  // Interpolation pipeline
  logic [IDX_W-1:0]        seg_idx_r;     // Current interval
  logic [CYC_W-1:0]        frac_r;        // Offset within interval

  // Per-axis state
  logic [NUM_AXES-1:0][POS_W-1:0] change_r;     // Slave change per cycle
  logic [NUM_AXES-1:0][POS_W-1:0] eng_pos_r;    // Engage master position
  logic [NUM_AXES-1:0][POS_W-1:0] dis_pos_r;    // Disengage master position
  logic [NUM_AXES-1:0]            eng_arm_r;    // Engage pending
  logic [NUM_AXES-1:0]            dis_arm_r;    // Disengage pending
  logic [NUM_AXES-1:0]            engaged_r;    // Slave follows table
  logic [NUM_AXES-1:0][POS_W-1:0] cmd_r;        // Slave command

  // Bus decode
  wire               bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire               wr_en    = bus_req & wb_we_i;
  wire [4:0]         grp      = wb_adr_i[9:5];
  wire [AXIS_W-1:0]  ax_sel   = wb_adr_i[4:2];
  wire               wr_ctrl  = wr_en & (wb_adr_i == ADR_CTRL);
  wire               setup_ok = master_ok_r;  // Other setup waits for a master
  wire               wr_cyc   = wr_en & setup_ok & (wb_adr_i == ADR_CYCLE);
  wire               wr_intv  = wr_en & setup_ok & (wb_adr_i == ADR_INTERVAL);
  wire               wr_strt  = wr_en & setup_ok & (wb_adr_i == ADR_START);
  wire               wr_tidx  = wr_en & setup_ok & (wb_adr_i == ADR_TBL_IDX);
  wire               wr_tax   = wr_en & setup_ok & (wb_adr_i == ADR_TBL_AXIS);
  wire               wr_tdat  = wr_en & setup_ok & (wb_adr_i == ADR_TBL_DATA);
  wire               wr_chg   = wr_en & setup_ok & (grp == GRP_CHANGE);
  wire               wr_eng   = wr_en & setup_ok & (grp == GRP_ENGAGE);
  wire               wr_dis   = wr_en & setup_ok & (grp == GRP_DISENG);
  wire [31:0]        ctrl_rd  = {24'h000000, master_ok_r, master_ax_r, 3'h0, enable_r};
  wire [31:0]        ctrl_new = merge(ctrl_rd, wb_dat_i, wb_sel_i);
  wire [31:0]        cyc_new  = merge({9'h000, cycle_r}, wb_dat_i, wb_sel_i);
  wire [31:0]        intv_new = merge({9'h000, interval_r}, wb_dat_i, wb_sel_i);
  wire [31:0]        strt_new = merge({9'h000, start_r}, wb_dat_i, wb_sel_i);

  // Read data selection; unmapped addresses read zero
  wire [31:0] status_rd = {8'h00, dis_arm_r, eng_arm_r, engaged_r};
  wire [31:0] tbl_rd    = (tbl_idx_r < IDX_W'(NUM_POINTS)) ?
                          table_r[tbl_idx_r][tbl_ax_r] : 32'h00000000;
  wire [31:0] rd_data   =
    (wb_adr_i == ADR_CTRL)     ? ctrl_rd :
    (wb_adr_i == ADR_CYCLE)    ? {9'h000, cycle_r} :
    (wb_adr_i == ADR_INTERVAL) ? {9'h000, interval_r} :
    (wb_adr_i == ADR_START)    ? {9'h000, start_r} :
    (wb_adr_i == ADR_STATUS)   ? status_rd :
    (wb_adr_i == ADR_MPOS)     ? {9'h000, mpos_r} :
    (wb_adr_i == ADR_TBL_IDX)  ? {23'h000000, tbl_idx_r} :
    (wb_adr_i == ADR_TBL_AXIS) ? {29'h00000000, tbl_ax_r} :
    (wb_adr_i == ADR_TBL_DATA) ? tbl_rd :
    (grp == GRP_CHANGE)        ? change_r[ax_sel] :
    (grp == GRP_ENGAGE)        ? eng_pos_r[ax_sel] :
    (grp == GRP_DISENG)        ? dis_pos_r[ax_sel] : 32'h00000000;

  // Wishbone answer: ack one cycle after the request, dropped the next
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_data;
    end
  end

  // Control register: enable and master selection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_r    <= 1'b0;
      master_ax_r <= MASTER_RST;
      master_ok_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      enable_r    <= ctrl_new[CTRL_EN_BIT];
      master_ax_r <= ctrl_new[CTRL_AX_LSB +: AXIS_W];
      master_ok_r <= ctrl_new[CTRL_SEL_BIT];
    end
  end

  // Setup registers; field widths cap the accepted range
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cycle_r    <= CYCLE_RST;
      interval_r <= INTERVAL_RST;
      start_r    <= START_RST;
      tbl_idx_r  <= '0;
      tbl_ax_r   <= '0;
    end
    else
    begin
      if (wr_cyc)
      begin
        cycle_r <= cyc_new[CYC_W-1:0] & CYCLE_MAX;
      end
      if (wr_intv)
      begin
        interval_r <= intv_new[CYC_W-1:0];
      end
      if (wr_strt)
      begin
        start_r <= strt_new[CYC_W-1:0];
      end
      if (wr_tidx)
      begin
        tbl_idx_r <= wb_dat_i[IDX_W-1:0];
      end
      if (wr_tax)
      begin
        tbl_ax_r <= wb_dat_i[AXIS_W-1:0];
      end
    end
  end

  // Table storage; points past 256 are dropped
  always_ff @(posedge clk_i)
  begin
    if (wr_tdat && (tbl_idx_r < IDX_W'(NUM_POINTS)))
    begin
      table_r[tbl_idx_r][tbl_ax_r] <= merge(tbl_rd, wb_dat_i, wb_sel_i);
    end
  end

  // Master step, taken from the selected main encoder input
  wire               cam_on  = enable_r & master_ok_r;
  wire [POS_W-1:0]   enc_sel = main_enc_i[master_ax_r];
  wire [POS_W-1:0]   delta   = enc_sel - enc_prev_r;
  wire signed [33:0] msum    = $signed({11'h000, mpos_r}) +
                               $signed({{2{delta[31]}}, delta});
  wire signed [33:0] cyc_s   = $signed({11'h000, cycle_r});
  wire               wrap_hi = msum >= cyc_s;
  wire               wrap_lo = msum < 34'sh0;
  // Single correction per step: the master must move under one cycle per sample
  wire signed [33:0] mwrap   = wrap_hi ? (msum - cyc_s) :
                               wrap_lo ? (msum + cyc_s) : msum;
  wire [CYC_W-1:0]   mpos_nxt = (cam_on && (cycle_r != '0)) ?
                                mwrap[CYC_W-1:0] : '0;
  wire               fwd     = cam_on & ~delta[31] & (delta != '0);
  wire               wrapped = fwd & wrap_hi;

  // Master tracking registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enc_prev_r <= POS_RST;
      mpos_r     <= '0;
      fwd_r      <= 1'b0;
    end
    else
    begin
      enc_prev_r <= enc_sel;
      mpos_r     <= mpos_nxt;
      fwd_r      <= fwd;
    end
  end

  // Locate master within the table: offset from the first point
  wire signed [33:0] odiff   = $signed({11'h000, mpos_r}) - $signed({11'h000, start_r});
  wire signed [33:0] ooff    = (odiff < 34'sh0) ? (odiff + cyc_s) : odiff;
  wire [CYC_W-1:0]   off     = ooff[CYC_W-1:0];
  wire               no_intv = (interval_r == '0);
  wire [CYC_W-1:0]   seg_q   = no_intv ? '0 : (off / interval_r);
  wire [CYC_W-1:0]   seg_rem = no_intv ? '0 : (off % interval_r);
  wire               seg_ovf = seg_q > {14'h0000, LAST_SEG};
  // Beyond the last interval the end point is held
  wire [IDX_W-1:0]   seg_nxt = seg_ovf ? LAST_SEG : seg_q[IDX_W-1:0];
  wire [CYC_W-1:0]   frac_nxt = seg_ovf ? interval_r : seg_rem;

  // Interval pipeline stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seg_idx_r <= '0;
      frac_r    <= '0;
    end
    else
    begin
      seg_idx_r <= seg_nxt;
      frac_r    <= frac_nxt;
    end
  end

  // Per-axis interpolation, scheduling and engagement
  for (genvar i = 0; i < NUM_AXES; i++)
  begin : g_axis
    wire               is_slave = (master_ax_r != AXIS_W'(i));
    wire [POS_W-1:0]   p0       = table_r[seg_idx_r][i];
    wire [POS_W-1:0]   p1       = table_r[seg_idx_r + IDX_W'(1)][i];
    wire signed [63:0] pdiff    = $signed({{32{p1[31]}}, p1}) -
                                  $signed({{32{p0[31]}}, p0});
    wire signed [63:0] prod     = pdiff * $signed({41'h0, frac_r});
    wire signed [63:0] quot     = no_intv ? 64'sh0 :
                                  (prod / $signed({41'h0, interval_r}));
    wire signed [63:0] ival     = $signed({{32{p0[31]}}, p0}) + quot;
    wire signed [63:0] chg_s    = $signed({32'h00000000, change_r[i]});
    wire               chg_zero = (change_r[i] == '0);
    // Fold into one slave cycle; end of cycle reads as zero
    wire signed [63:0] mval     = chg_zero ? ival :
                                  (ival >= chg_s) ? (ival - chg_s) :
                                  (ival < 64'sh0) ? (ival + chg_s) : ival;
    wire [POS_W-1:0]   chg_new  = merge(change_r[i], wb_dat_i, wb_sel_i);
    wire [POS_W-1:0]   eng_new  = merge(eng_pos_r[i], wb_dat_i, wb_sel_i);
    wire [POS_W-1:0]   dis_new  = merge(dis_pos_r[i], wb_dat_i, wb_sel_i);
    wire               wr_c     = wr_chg & (ax_sel == AXIS_W'(i));
    wire               wr_e     = wr_eng & (ax_sel == AXIS_W'(i));
    wire               wr_d     = wr_dis & (ax_sel == AXIS_W'(i));
    wire               eng_out  = eng_new >= {9'h000, cycle_r};
    wire               dis_out  = dis_new >= {9'h000, cycle_r};
    wire               eng_hit  = eng_arm_r[i] & fwd &
                                  crossed(eng_pos_r[i], mpos_r, mpos_nxt, wrapped);
    wire               dis_hit  = dis_arm_r[i] & fwd &
                                  crossed(dis_pos_r[i], mpos_r, mpos_nxt, wrapped);

    // Slave change, engage and disengage registers; change drops bit 31, keeping bits 30:0
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        change_r[i]  <= POS_RST;
        eng_pos_r[i] <= POS_RST;
        dis_pos_r[i] <= POS_RST;
      end
      else
      begin
        if (wr_c)
        begin
          change_r[i] <= chg_new & CHANGE_MAX;
        end
        if (wr_e)
        begin
          eng_pos_r[i] <= eng_new;
        end
        if (wr_d)
        begin
          dis_pos_r[i] <= dis_new;
        end
      end
    end

    // Engagement state; leaving cam mode or becoming master drops everything
    always_ff @(posedge clk_i)
    begin
      if (rst_i || !cam_on || !is_slave)
      begin
        eng_arm_r[i] <= 1'b0;
        dis_arm_r[i] <= 1'b0;
        engaged_r[i] <= 1'b0;
      end
      else if (wr_d)
      begin
        // Newest command wins over a pending engage
        eng_arm_r[i] <= 1'b0;
        dis_arm_r[i] <= ~dis_out;
        engaged_r[i] <= dis_out ? 1'b0 : engaged_r[i];
      end
      else if (wr_e)
      begin
        dis_arm_r[i] <= 1'b0;
        eng_arm_r[i] <= ~eng_out;
        engaged_r[i] <= eng_out ? 1'b1 : engaged_r[i];
      end
      else if (eng_hit)
      begin
        eng_arm_r[i] <= 1'b0;
        engaged_r[i] <= 1'b1;
      end
      else if (dis_hit)
      begin
        dis_arm_r[i] <= 1'b0;
        engaged_r[i] <= 1'b0;
      end
    end

    // Slave command: follows the table while engaged, holds otherwise
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        cmd_r[i] <= POS_RST;
      end
      else if (engaged_r[i])
      begin
        cmd_r[i] <= mval[POS_W-1:0];
      end
    end
  end

  // Outputs, all from flip-flops
  assign slave_cmd_o     = cmd_r;
  assign slave_engaged_o = engaged_r;
  assign master_pos_o    = mpos_r;
  assign master_fwd_o    = fwd_r;

endmodule : electronic_cam_follower

`default_nettype wire

// [tb/electronic_cam_follower_properties.sv]
`timescale 1ns/1ns
`default_nettype none

module cam_follower_checker
  import cam_pkg::*;
(
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic [ADR_W-1:0]               wb_adr_i,
  input  wire logic [31:0]                    wb_dat_i,
  input  wire logic                           wb_we_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_ack_o,
  input  wire logic [NUM_AXES-1:0][POS_W-1:0] slave_cmd_o,
  input  wire logic [NUM_AXES-1:0]            slave_engaged_o,
  input  wire logic [CYC_W-1:0]               master_pos_o,
  input  wire logic                           master_fwd_o
);
  logic [CYC_W-1:0] cyc_sh_r;   // Shadow of the master cycle length
  logic             en_sh_r;    // Shadow of the cam enable
  logic             sel_sh_r;   // Shadow of master selected
  wire              wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

  // Shadow config from taken writes; full-word lanes only, as the bench uses
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cyc_sh_r <= '0;
      en_sh_r  <= 1'b0;
      sel_sh_r <= 1'b0;
    end
    else if (wr_take && wb_adr_i == ADR_CTRL)
    begin
      sel_sh_r <= wb_dat_i[CTRL_SEL_BIT];
      en_sh_r  <= wb_dat_i[CTRL_EN_BIT];
    end
    else if (wr_take && wb_adr_i == ADR_CYCLE && sel_sh_r)
      cyc_sh_r <= wb_dat_i[CYC_W-1:0];
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_pos_wrapped: assert property (
    cyc_sh_r != '0 |-> master_pos_o < cyc_sh_r)
    else $error("master position beyond cycle");
  a_off_quiet: assert property (
    !en_sh_r && !$past(en_sh_r) && !$past(en_sh_r, 2)
    |-> master_pos_o == '0 && slave_engaged_o == '0)
    else $error("activity while cam disabled");
  a_cmd_hold: assert property (
    slave_engaged_o == '0 && $past(slave_engaged_o) == '0
    && $past(slave_engaged_o, 2) == '0 && $past(slave_engaged_o, 3) == '0
    |-> $stable(slave_cmd_o))
    else $error("slave command moved while idle");
  a_fwd_flag: assert property (
    master_pos_o > $past(master_pos_o)
    && master_pos_o - $past(master_pos_o) < 23'h0003e8 |-> master_fwd_o)
    else $error("forward flag low on forward step");
  a_back_flag: assert property (
    master_pos_o < $past(master_pos_o)
    && $past(master_pos_o) - master_pos_o < 23'h0003e8 |-> !master_fwd_o)
    else $error("forward flag high on backward step");
  a_engage_cause: assert property (
    (slave_engaged_o & ~$past(slave_engaged_o)) != '0
    |-> master_fwd_o || wb_ack_o)
    else $error("engage without write or forward travel");
endmodule : cam_follower_checker

`default_nettype wire

// [tb/main_encoder_model.sv]
`timescale 1ns/1ns
`default_nettype none

// Main encoder counts; only the selected axis moves, by step each clock while run_i is high
module main_encoder_model
  import cam_pkg::*;
(
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic [AXIS_W-1:0]              axis_i,
  input  wire logic signed [POS_W-1:0]        step_i,
  input  wire logic                           run_i,
  output logic      [NUM_AXES-1:0][POS_W-1:0] enc_o
);
  // Counter per main encoder port; negative step models reverse travel
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      enc_o <= '0;
    else if (run_i)
      enc_o[axis_i] <= enc_o[axis_i] + step_i;
  end
endmodule : main_encoder_model

`default_nettype wire

// [tb/electronic_cam_follower_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module electronic_cam_follower_tb_top;
  import cam_pkg::*;

  logic                           clk_i;
  logic                           rst_i = 1'b1;
  logic [ADR_W-1:0]               adr   = '0;
  logic [31:0]                    wdat  = '0;
  logic [3:0]                     sel   = 4'hf;   // Full words only
  logic                           we    = 1'b0;
  logic                           cyc   = 1'b0;
  logic                           stb   = 1'b0;
  logic [31:0]                    rdat;
  logic                           ack;
  logic [NUM_AXES-1:0][POS_W-1:0] enc;
  logic [NUM_AXES-1:0][POS_W-1:0] cmd;
  logic [NUM_AXES-1:0]            eng;
  logic [CYC_W-1:0]               mpos;
  logic                           fwd;
  logic signed [POS_W-1:0]        step  = '0;     // Encoder step per clock
  logic                           run   = 1'b0;
  int                             failures = 0;
  int                             comparisons = 0;
  // Slave profile at master 0, 2000, 4000 and 6000
  localparam int CAM_PTS [4] = '{0, 3000, 2250, 1500};

  electronic_cam_follower dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .main_enc_i(enc), .slave_cmd_o(cmd),
    .slave_engaged_o(eng), .master_pos_o(mpos), .master_fwd_o(fwd));

  // Axis 1 is the cam master throughout
  main_encoder_model enc_src (.clk_i(clk_i), .rst_i(rst_i), .axis_i(3'h1),
    .step_i(step), .run_i(run), .enc_o(enc));

  // Clock, 50 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Classic single cycle; waits on ack, the watchdog bounds it
  task wb(input logic [ADR_W-1:0] a, input logic w, input logic [31:0] d,
          output logic [31:0] q);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask : wr

  task rd(input logic [ADR_W-1:0] a, output logic [31:0] q);
    wb(a, 1'b0, 32'h0, q);
  endtask : rd

  // Per-axis register address
  function automatic logic [ADR_W-1:0] ax(input logic [4:0] g, input int a);
    return {g, a[2:0], 2'b00};
  endfunction : ax

  // Drives the master for n clocks, then lets the 2-stage pipeline settle
  task move(input int s, input int n);
    @(posedge clk_i);
    step <= s;
    run  <= 1'b1;
    repeat (n) @(posedge clk_i);
    run <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : move

  task t_setup;
    logic [31:0] q;
    wr(ADR_CYCLE, 32'h123);
    rd(ADR_CYCLE, q);
    check("cycle before select", q, 32'h0);
    wr(ADR_CTRL, 32'h90);
    rd(ADR_CTRL, q);
    check("ctrl", q, 32'h90);
    wr(ADR_CYCLE, 32'hffffffff);
    rd(ADR_CYCLE, q);
    check("cycle max", q, 32'(CYCLE_MAX));
    wr(ax(GRP_CHANGE, 3), 32'hffffffff);
    rd(ax(GRP_CHANGE, 3), q);
    check("change max", q, CHANGE_MAX);
    wr(ADR_CYCLE, 32'h1770);             // 6000 counts
    wr(ADR_INTERVAL, 32'h7d0);           // 2000 counts
    wr(ADR_START, 32'h0);
    rd(ADR_INTERVAL, q);
    check("interval", q, 32'h7d0);
    wr(ax(GRP_CHANGE, 0), 32'h5dc);
    // Same profile on every axis, so no engaged slave reads an unwritten point
    for (int i = 0; i < 4; i++)
    begin
      wr(ADR_TBL_IDX, 32'(i));
      for (int a = 0; a < NUM_AXES; a++)
      begin
        wr(ADR_TBL_AXIS, 32'(a));
        wr(ADR_TBL_DATA, 32'(CAM_PTS[i]));
      end
    end
    wr(ADR_TBL_AXIS, 32'h0);
    wr(ADR_TBL_IDX, 32'h2);
    rd(ADR_TBL_DATA, q);
    check("table point 2", q, 32'h8ca);
    wr(ADR_TBL_IDX, 32'h100);
    wr(ADR_TBL_DATA, 32'h55);
    rd(ADR_TBL_DATA, q);
    check("table point 256", q, 32'h55);
    wr(ADR_TBL_IDX, 32'h101);
    rd(ADR_TBL_DATA, q);
    check("table point 257", q, 32'h0);
    rd(10'h3fc, q);
    check("unmapped", q, 32'h0);
  endtask : t_setup

  // Enable, engage every axis at once; master axis must stay out
  task t_engage_all;
    logic [31:0] q;
    wr(ADR_CTRL, 32'h91);
    for (int a = 0; a < NUM_AXES; a++)
      wr(ax(GRP_ENGAGE, a), 32'h1770);
    repeat (3) @(posedge clk_i);
    check("engaged all", 32'(eng), 32'hfd);
    rd(ADR_STATUS, q);
    check("status", {8'h0, q[23:0]}, 32'hfd);
  endtask : t_engage_all

  task t_follow;
    logic [31:0] q;
    move(100, 30);
    check("master mid", 32'(mpos), 32'hbb8);
    rd(ADR_MPOS, q);
    check("master reg", q, 32'hbb8);
    check("slave mid", cmd[0], 32'h465);
    move(100, 30);
    check("master wrap", 32'(mpos), 32'h0);
    check("slave wrap", cmd[0], 32'h0);
  endtask : t_follow

  task t_release;
    for (int a = 0; a < NUM_AXES; a++)
      wr(ax(GRP_DISENG, a), 32'h1b58);
    repeat (3) @(posedge clk_i);
    check("released", 32'(eng), 32'h0);
  endtask : t_release

  // Scheduled points on axis 2, crossed backward then forward
  task t_schedule;
    logic [31:0] q;
    move(100, 15);
    wr(ax(GRP_ENGAGE, 2), 32'h3e8);
    rd(ADR_STATUS, q);
    check("armed", {8'h0, q[23:0]}, 32'h400);
    move(-100, 10);
    check("master back", 32'(mpos), 32'h1f4);
    check("no backward engage", 32'(eng), 32'h0);
    move(100, 10);
    check("forward engage", 32'(eng), 32'h4);
    wr(ax(GRP_DISENG, 2), 32'h7d0);
    move(100, 10);
    check("scheduled release", 32'(eng), 32'h0);
  endtask : t_schedule

  task t_disable;
    wr(ax(GRP_ENGAGE, 0), 32'h1770);
    wr(ADR_CTRL, 32'h90);
    repeat (3) @(posedge clk_i);
    check("off master", 32'(mpos), 32'h0);
    check("off engaged", 32'(eng), 32'h0);
  endtask : t_disable

  task final_report;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_setup;
    t_engage_all;
    t_follow;
    t_release;
    t_schedule;
    t_disable;
    final_report;
  end

  // Watchdog; the full run needs well under 2000 clocks
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    final_report;
  end
endmodule : electronic_cam_follower_tb_top

bind electronic_cam_follower cam_follower_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .slave_cmd_o(slave_cmd_o),
  .slave_engaged_o(slave_engaged_o), .master_pos_o(master_pos_o),
  .master_fwd_o(master_fwd_o));

`default_nettype wire
